//--- core/core_status_flags.sv
// design: core status register, flag logic and data memory bank decode
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// RL1 - clear of status zeroes upper, sets zero
// RL2 - status destination blocks writes to arithmetic flags; code blocks them only for flag-updating ops, a move writes them
// RL3 - software cannot write time-out or power-down
// RL4 - time-out set by power-up, clear, sleep
// RL5 - power-down set power-up/clear, cleared by sleep
// RL6 - zero flag follows result equal zero
// RL7 - digit carry from bit three, carry from msb
// RL8 - borrow reported inverted: one means none
// RL9 - subtract by adding two's complement
// RL10 - rotates load carry from msb or lsb
// RL11 - top three status bits read zero
// RL12 - core registers at first twelve bank addresses
// RL13 - peripheral area x0c..x1f every bank
// RL14 - up to eighty general ram bytes per bank
// RL15 - sixteen common bytes shared by all banks
// RL16 - file pointer reaches general ram linearly
module core_status_flags #(
  parameter int unsigned data_width = 8, // alu width
  parameter int unsigned bank_bits = 5 // number of bank select bits
) (
  input wire logic clock, // core clock, 250 MHz
  input wire logic resetn, // asynchronous power-up reset, active low
  input wire logic enable, // clock enable, freezes all state when low
  input wire logic exec, // one instruction executes this cycle
  input wire logic [3:0] op, // operation, a core_status_pkg::op_t code
  input wire logic [data_width-1:0] operand_a, // first operand, source register for rotates
  input wire logic [data_width-1:0] operand_b, // second operand
  input wire logic dest_is_status, // instruction writes its result to the status register
  input wire logic timeout_event, // watchdog timer expired
  input wire logic [11:0] mem_addr, // banked data address: bank and 7-bit offset
  input wire logic [15:0] file_pointer, // linear pointer value
  output logic [7:0] core_status_ff, // status register as read
  output logic [data_width-1:0] result_ff, // alu result
  output logic [2:0] region_ff, // region decoded from mem_addr
  output logic [10:0] ram_index_ff, // physical ram index for mem_addr
  output logic [10:0] linear_index_ff, // physical ram index for file_pointer
  output logic linear_hit_ff // file_pointer falls in the linear ram window
);
  // ****************************************
  // checks
  // ****************************************
  // refused at elaboration: the flag logic is written for an 8-bit alu
  if (data_width != 8) begin : g_width_check
    $error("data_width must be 8");
  end
  // mem_addr carries five bank bits, so more banks cannot be reached
  if (bank_bits < 1 || bank_bits > 5) begin : g_bank_check
    $error("bank_bits must be 1..5");
  end

  // ****************************************
  // helper functions
  // ****************************************
  // region of a bank offset, used for direct decode
  function automatic logic [2:0] region_of(input logic [6:0] off);
    if (off < core_status_pkg::core_reg_count) region_of = 3'(core_status_pkg::reg_core); // [RL12]
    else if (off <= core_status_pkg::periph_last) region_of = 3'(core_status_pkg::reg_periph); // [RL13]
    else if (off <= core_status_pkg::ram_last) region_of = 3'(core_status_pkg::reg_ram); // [RL14]
    else region_of = 3'(core_status_pkg::reg_common); // [RL15]
  endfunction : region_of

  // ****************************************
  // alu: add, subtract, logic, rotate
  // ****************************************
  logic [4:0] low_sum; // low nibble sum, bit 4 is digit carry
  logic [8:0] full_sum; // full sum, bit 8 is carry
  logic [7:0] addend; // operand b or its two's complement
  logic [7:0] nxt_result;
  logic nxt_c, nxt_digit, upd_c, upd_digit, upd_z;
  logic [7:0] nxt_status;
  core_status_pkg::op_t op_q;

  always_comb begin
    op_q = core_status_pkg::op_t'(op);
    // subtraction adds the two's complement, so carry reads as not-borrow
    addend = (op_q == core_status_pkg::op_sub) ? 8'(~operand_b + 8'h01) : operand_b; // [RL9] [RL8]
    low_sum = {1'b0, operand_a[3:0]} + {1'b0, addend[3:0]};
    full_sum = {1'b0, operand_a} + {1'b0, addend};
    // a zero subtrahend gives complement 0 with no carry; force no-borrow
    if (op_q == core_status_pkg::op_sub && operand_b == 8'h00) begin // [RL8]
      low_sum[4] = 1'b1;
      full_sum[8] = 1'b1;
    end
    nxt_result = operand_a;
    nxt_c = core_status_ff[core_status_pkg::bit_carry];
    nxt_digit = core_status_ff[core_status_pkg::bit_digit_carry];
    upd_c = 1'b0;
    upd_digit = 1'b0;
    upd_z = 1'b0;
    case (op_q)
      core_status_pkg::op_add, core_status_pkg::op_sub: begin
        nxt_result = full_sum[7:0];
        nxt_digit = low_sum[4]; // [RL7]
        nxt_c = full_sum[8]; // [RL7]
        upd_c = 1'b1;
        upd_digit = 1'b1;
        upd_z = 1'b1;
      end
      core_status_pkg::op_logic: begin
        nxt_result = operand_a & operand_b;
        upd_z = 1'b1;
      end
      core_status_pkg::op_clear_file: begin
        nxt_result = 8'h00;
        upd_z = 1'b1;
      end
      core_status_pkg::op_rotate_left: begin
        nxt_result = {operand_a[6:0], core_status_ff[core_status_pkg::bit_carry]};
        nxt_c = operand_a[7]; // [RL10]
        upd_c = 1'b1;
      end
      core_status_pkg::op_rotate_right: begin
        nxt_result = {core_status_ff[core_status_pkg::bit_carry], operand_a[7:1]};
        nxt_c = operand_a[0]; // [RL10]
        upd_c = 1'b1;
      end
      core_status_pkg::op_move: begin
        nxt_result = operand_b;
      end
      default: begin
        nxt_result = operand_a;
      end
    endcase
  end

  // ****************************************
  // next status value
  // ****************************************
  always_comb begin
    nxt_status = core_status_ff;
    if (exec) begin
      // an op that touches any arithmetic flag blocks the data write to all three
      if (dest_is_status && !(upd_c || upd_digit || upd_z)) begin
        nxt_status[core_status_pkg::bit_carry] = nxt_result[core_status_pkg::bit_carry]; // [RL2]
        nxt_status[core_status_pkg::bit_digit_carry] = nxt_result[core_status_pkg::bit_digit_carry]; // [RL2]
        nxt_status[core_status_pkg::bit_zero] = nxt_result[core_status_pkg::bit_zero]; // [RL2]
      end
      if (upd_c) nxt_status[core_status_pkg::bit_carry] = nxt_c;
      if (upd_digit) nxt_status[core_status_pkg::bit_digit_carry] = nxt_digit;
      if (upd_z) nxt_status[core_status_pkg::bit_zero] = (nxt_result == 8'h00); // [RL6] [RL1]
      if (op_q == core_status_pkg::op_watchdog_clear) begin
        nxt_status[core_status_pkg::bit_timeout] = 1'b1; // [RL4]
        nxt_status[core_status_pkg::bit_powerdown] = 1'b1; // [RL5]
      end
      if (op_q == core_status_pkg::op_sleep) begin
        nxt_status[core_status_pkg::bit_timeout] = 1'b1; // [RL4]
        nxt_status[core_status_pkg::bit_powerdown] = 1'b0; // [RL5]
      end
    end
    // time-out event wins over an instruction in the same cycle
    if (timeout_event) nxt_status[core_status_pkg::bit_timeout] = 1'b0; // [RL4]
    nxt_status[7:5] = core_status_pkg::upper_reset; // [RL11] [RL1]
  end

  // ****************************************
  // status register; bits 4:3 never take written data
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      core_status_ff <= {core_status_pkg::upper_reset, core_status_pkg::timeout_reset,
                         core_status_pkg::powerdown_reset, core_status_pkg::flag_reset,
                         core_status_pkg::flag_reset, core_status_pkg::flag_reset}; // [RL4] [RL5]
    end else if (enable) begin
      core_status_ff <= nxt_status; // [RL3]
    end
  end

  // alu result register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      result_ff <= '0;
    end else if (enable && exec) begin
      result_ff <= nxt_result;
    end
  end

  // ****************************************
  // bank decode, direct and linear
  // ****************************************
  logic [15:0] lin_off; // offset into the linear window
  logic [10:0] lin_bank; // 80-byte chunk number
  logic [6:0] lin_byte; // byte within chunk
  always_comb begin
    lin_off = 16'(file_pointer - core_status_pkg::linear_base);
    lin_bank = 11'(lin_off / 16'(core_status_pkg::ram_per_bank));
    lin_byte = 7'(lin_off % 16'(core_status_pkg::ram_per_bank));
  end

  // decode registers, banked ram packs 80 bytes per bank, common ram at index 512, where 32 times 80 wraps in 11 bits
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      region_ff <= 3'(core_status_pkg::reg_none);
      ram_index_ff <= '0;
      linear_index_ff <= '0;
      linear_hit_ff <= 1'b0;
    end else if (enable) begin
      region_ff <= region_of(mem_addr[6:0]);
      if (mem_addr[6:0] >= core_status_pkg::common_first) begin
        // same storage whatever the bank
        ram_index_ff <= 11'(32 * core_status_pkg::ram_per_bank) + 11'(mem_addr[3:0]); // [RL15]
      end else begin
        // widen before multiplying: bank times 80 does not fit in seven bits
        ram_index_ff <= 11'(mem_addr[11:7]) * 11'(core_status_pkg::ram_per_bank) +
                        11'(mem_addr[6:0]) - 11'(core_status_pkg::ram_first); // [RL14]
      end
      // linear window concatenates each bank's general ram with no gaps
      linear_hit_ff <= (file_pointer >= core_status_pkg::linear_base) &&
                       (lin_bank < 11'(1 << bank_bits)); // [RL16]
      linear_index_ff <= 11'(lin_bank * 7'(core_status_pkg::ram_per_bank)) + 11'(lin_byte); // [RL16]
    end
  end

  // ****************************************
  // checks on the flag behaviour
  // ****************************************
  upper_zero_a: assert property (@(posedge clock) disable iff (!resetn)
    core_status_ff[7:5] == 3'h0) else $error("upper status bits not zero"); // [RL11]
  clear_status_a: assert property (@(posedge clock) disable iff (!resetn)
    enable && exec && op == 4'(core_status_pkg::op_clear_file) && dest_is_status && !timeout_event
    |=> core_status_ff[2] && core_status_ff[4:3] == $past(core_status_ff[4:3])
        && core_status_ff[1:0] == $past(core_status_ff[1:0])) else $error("clear of status wrong"); // [RL1]
  timeout_clear_a: assert property (@(posedge clock) disable iff (!resetn)
    enable && timeout_event |=> !core_status_ff[4]) else $error("time-out flag not cleared"); // [RL4]
  sleep_flags_a: assert property (@(posedge clock) disable iff (!resetn)
    enable && exec && op == 4'(core_status_pkg::op_sleep) && !timeout_event
    |=> core_status_ff[4:3] == 2'h2) else $error("sleep flags wrong"); // [RL5]
  wdclear_flags_a: assert property (@(posedge clock) disable iff (!resetn)
    enable && exec && op == 4'(core_status_pkg::op_watchdog_clear) && !timeout_event
    |=> core_status_ff[4:3] == 2'h3) else $error("watchdog clear flags wrong"); // [RL4]
  sticky_reset_a: assert property (@(posedge clock) disable iff (!resetn)
    enable && !timeout_event && !(exec && (op == 4'(core_status_pkg::op_sleep) ||
      op == 4'(core_status_pkg::op_watchdog_clear)))
    |=> $stable(core_status_ff[4:3])) else $error("reset flags written"); // [RL3]
  zero_flag_a: assert property (@(posedge clock) disable iff (!resetn)
    enable && exec && op == 4'(core_status_pkg::op_logic)
    |=> core_status_ff[2] == (result_ff == 8'h00)) else $error("zero flag mismatch"); // [RL6]
  sub_borrow_a: assert property (@(posedge clock) disable iff (!resetn)
    enable && exec && op == 4'(core_status_pkg::op_sub)
    |=> core_status_ff[0] == ($past(operand_a) >= $past(operand_b))) else $error("borrow wrong"); // [RL8]
  add_carry_a: assert property (@(posedge clock) disable iff (!resetn)
    enable && exec && op == 4'(core_status_pkg::op_add)
    |=> core_status_ff[0] == (9'($past(operand_a)) + 9'($past(operand_b)) > 9'h0ff))
    else $error("carry wrong"); // [RL7]
  rotate_left_a: assert property (@(posedge clock) disable iff (!resetn)
    enable && exec && op == 4'(core_status_pkg::op_rotate_left)
    |=> core_status_ff[0] == $past(operand_a[7])) else $error("rotate carry wrong"); // [RL10]
endmodule : core_status_flags
`default_nettype wire

//--- core/core_status_pkg.sv
// package: status register layout, op codes and data memory bank layout constants
package core_status_pkg;
  // ****************************************
  // status register layout
  // ****************************************
  localparam int unsigned status_width = 8;
  localparam int unsigned bit_carry = 0;
  localparam int unsigned bit_digit_carry = 1;
  localparam int unsigned bit_zero = 2;
  localparam int unsigned bit_powerdown = 3;
  localparam int unsigned bit_timeout = 4;
  localparam logic [2:0] upper_reset = 3'h0; // unimplemented bits read zero
  localparam logic flag_reset = 1'h0; // arithmetic flags after reset
  localparam logic timeout_reset = 1'h1; // watchdog time-out flag after power-up
  localparam logic powerdown_reset = 1'h1; // power-down flag after power-up
  // ****************************************
  // bank layout, offsets within a 128-byte bank
  // ****************************************
  localparam logic [6:0] core_reg_count = 7'h0c; // core registers 0x00..0x0b
  localparam logic [6:0] status_offset = 7'h03; // status register within the core block
  localparam logic [6:0] periph_first = 7'h0c; // peripheral area start
  localparam logic [6:0] periph_last = 7'h1f; // peripheral area end, 20 bytes
  localparam logic [6:0] ram_first = 7'h20; // general ram start
  localparam logic [6:0] ram_last = 7'h6f; // general ram end, 80 bytes
  localparam logic [6:0] common_first = 7'h70; // common ram start, 16 bytes
  localparam logic [15:0] linear_base = 16'h2000; // base of linear general ram window
  localparam int unsigned ram_per_bank = 80;
  // ****************************************
  // operations steering the flags
  // ****************************************
  typedef enum logic [3:0] {
    op_none = 4'h0, op_add = 4'h1, op_sub = 4'h2, op_logic = 4'h3, op_clear_file = 4'h4,
    op_rotate_left = 4'h5, op_rotate_right = 4'h6, op_watchdog_clear = 4'h7, op_sleep = 4'h8,
    op_move = 4'h9
  } op_t;
  // ****************************************
  // region decoded from an address
  // ****************************************
  typedef enum logic [2:0] {
    reg_core = 3'h0, reg_periph = 3'h1, reg_ram = 3'h3, reg_common = 3'h2, reg_none = 3'h6
  } region_t;
endpackage : core_status_pkg

//--- tb/core_status_exec_model.sv
// partner model: instruction execution unit issuing one operation at a time
`timescale 1ns/10ps
`default_nettype none
module core_status_exec_model (
  input wire logic clock,
  output logic exec,
  output logic [3:0] op,
  output logic [7:0] operand_a,
  output logic [7:0] operand_b,
  output logic dest_is_status,
  output logic timeout_event
);
  // ****************************************
  // idle values at time zero
  // ****************************************
  initial begin
    exec = 1'b0;
    op = 4'h0;
    operand_a = 8'h00;
    operand_b = 8'h00;
    dest_is_status = 1'b0;
    timeout_event = 1'b0;
  end
  // one instruction: held across the taking edge, then released
  // operands are inverted after release so stale values never look valid
  task automatic issue(input logic [3:0] o, input logic [7:0] a, input logic [7:0] b, input logic d,
                       input logic t);
    @(posedge clock);
    exec <= 1'b1;
    op <= o;
    operand_a <= a;
    operand_b <= b;
    dest_is_status <= d;
    timeout_event <= t;
    @(posedge clock);
    exec <= 1'b0;
    op <= 4'h0;
    operand_a <= ~a;
    operand_b <= ~b;
    dest_is_status <= 1'b0;
    timeout_event <= 1'b0;
  endtask : issue
endmodule : core_status_exec_model
`default_nettype wire

//--- tb/core_status_flags_and_bank_layout_tb_top.sv
// testbench: status flag table, bank decode table, freeze and reset cases
`timescale 1ns/10ps
`default_nettype none
`define chk(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module core_status_flags_and_bank_layout_tb_top;
  // ****************************************
  // stimulus tables
  // ****************************************
  typedef struct packed {
    core_status_pkg::op_t op; logic [7:0] a; logic [7:0] b; logic d; logic t;
    logic [7:0] res; logic [7:0] rm; logic [7:0] st; logic [7:0] sm;
  } row_t;
  typedef struct packed {
    logic [11:0] addr; logic [15:0] fp; core_status_pkg::region_t rg; logic [10:0] idx; logic [10:0] lin; logic hit;
  } mrow_t;
  logic clock, resetn, enable, exec, dest_is_status, timeout_event, linear_hit_ff;
  logic [3:0] op;
  logic [7:0] operand_a, operand_b, core_status_ff, result_ff, held;
  logic [11:0] mem_addr;
  logic [15:0] file_pointer;
  logic [2:0] region_ff;
  logic [10:0] ram_index_ff, linear_index_ff;
  int fail_count = 0;
  int num_checks = 0;
  // flags chain from row to row, so the order of rows matters
  row_t rows [17] = '{
    '{core_status_pkg::op_sub, 8'h05, 8'h06, 1'b0, 1'b0, 8'hff, 8'hff, 8'h18, 8'hff},
    '{core_status_pkg::op_add, 8'hff, 8'h01, 1'b0, 1'b0, 8'h00, 8'hff, 8'h1f, 8'hff},
    '{core_status_pkg::op_sub, 8'h05, 8'h00, 1'b0, 1'b0, 8'h05, 8'hff, 8'h1b, 8'hff},
    '{core_status_pkg::op_sub, 8'h10, 8'h01, 1'b0, 1'b0, 8'h0f, 8'hff, 8'h19, 8'hff},
    '{core_status_pkg::op_logic, 8'h0f, 8'hf0, 1'b0, 1'b0, 8'h00, 8'hff, 8'h1d, 8'hff},
    '{core_status_pkg::op_rotate_left, 8'h80, 8'h00, 1'b0, 1'b0, 8'h01, 8'hff, 8'h01, 8'h01},
    '{core_status_pkg::op_rotate_right, 8'h80, 8'h00, 1'b0, 1'b0, 8'hc0, 8'hff, 8'h00, 8'h01},
    '{core_status_pkg::op_rotate_left, 8'h7f, 8'h00, 1'b0, 1'b0, 8'hfe, 8'hff, 8'h00, 8'h01},
    '{core_status_pkg::op_rotate_right, 8'h01, 8'h00, 1'b0, 1'b0, 8'h00, 8'hff, 8'h01, 8'h01},
    '{core_status_pkg::op_clear_file, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00, 8'hff, 8'h1d, 8'hff},
    '{core_status_pkg::op_move, 8'h00, 8'hff, 1'b1, 1'b0, 8'hff, 8'hff, 8'h1f, 8'hff},
    '{core_status_pkg::op_move, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00, 8'hff, 8'h18, 8'hff},
    '{core_status_pkg::op_add, 8'h0f, 8'h01, 1'b1, 1'b0, 8'h10, 8'hff, 8'h1a, 8'hff},
    '{core_status_pkg::op_sleep, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00, 8'h00, 8'h12, 8'hff},
    '{core_status_pkg::op_none, 8'h00, 8'h00, 1'b0, 1'b1, 8'h00, 8'h00, 8'h02, 8'hff},
    '{core_status_pkg::op_watchdog_clear, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00, 8'h00, 8'h1a, 8'hff},
    '{core_status_pkg::op_watchdog_clear, 8'h00, 8'h00, 1'b0, 1'b1, 8'h00, 8'h00, 8'h0a, 8'hff}};
  // bank offsets at each region edge except the core block, checked at the status offset, and linear window edges
  mrow_t mrows [7] = '{
    '{12'h103, 16'h2000, core_status_pkg::reg_core, 11'h000, 11'd0, 1'b1},
    '{12'h08c, 16'h204f, core_status_pkg::reg_periph, 11'h000, 11'd79, 1'b1},
    '{12'h01f, 16'h2050, core_status_pkg::reg_periph, 11'h000, 11'd80, 1'b1},
    '{12'h120, 16'h29ff, core_status_pkg::reg_ram, 11'd160, 11'd2559, 1'b1},
    '{12'h0ef, 16'h1fff, core_status_pkg::reg_ram, 11'd159, 11'd0, 1'b0},
    '{12'h070, 16'h2a00, core_status_pkg::reg_common, 11'd2560, 11'd0, 1'b0},
    '{12'h2ff, 16'h0000, core_status_pkg::reg_common, 11'd2575, 11'd0, 1'b0}};
  // ****************************************
  // design, partner and clock
  // ****************************************
  core_status_flags u_core_status_flags (.clock(clock), .resetn(resetn), .enable(enable), .exec(exec), .op(op),
    .operand_a(operand_a), .operand_b(operand_b), .dest_is_status(dest_is_status),
    .timeout_event(timeout_event), .mem_addr(mem_addr), .file_pointer(file_pointer),
    .core_status_ff(core_status_ff), .result_ff(result_ff), .region_ff(region_ff), .ram_index_ff(ram_index_ff),
    .linear_index_ff(linear_index_ff), .linear_hit_ff(linear_hit_ff));
  core_status_exec_model u_core_status_exec_model (.clock(clock), .exec(exec), .op(op), .operand_a(operand_a),
    .operand_b(operand_b), .dest_is_status(dest_is_status), .timeout_event(timeout_event));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // verdict in one place, reached by the main sequence or the hang limit
  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  initial begin
    #100000;
    fail_count++;
    results();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    resetn = 1'b0;
    enable = 1'b1;
    mem_addr = 12'h000;
    file_pointer = 16'h0000;
    repeat (6) @(posedge clock);
    #1;
    `chk(core_status_ff, 8'h18)
    `chk(region_ff, 3'(core_status_pkg::reg_none))
    `chk(result_ff, 8'h00)
    @(posedge clock);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      u_core_status_exec_model.issue(rows[i].op, rows[i].a, rows[i].b, rows[i].d, rows[i].t);
      #1;
      `chk(result_ff & rows[i].rm, rows[i].res & rows[i].rm)
      `chk(core_status_ff & rows[i].sm, rows[i].st)
    end
    foreach (mrows[i]) begin
      @(posedge clock);
      mem_addr <= mrows[i].addr;
      file_pointer <= mrows[i].fp;
      @(posedge clock);
      #1;
      `chk(region_ff, 3'(mrows[i].rg))
      if (mrows[i].rg inside {core_status_pkg::reg_ram, core_status_pkg::reg_common})
        `chk(ram_index_ff, mrows[i].idx)
      `chk(linear_hit_ff, mrows[i].hit)
      if (mrows[i].hit) `chk(linear_index_ff, mrows[i].lin)
    end
    // a held clock enable must freeze flags and result
    held = core_status_ff;
    @(posedge clock);
    enable <= 1'b0;
    u_core_status_exec_model.issue(4'(core_status_pkg::op_add), 8'hff, 8'h01, 1'b0, 1'b1);
    #1;
    `chk(core_status_ff, held)
    `chk(result_ff, 8'h00)
    // second reset in mid-run restores power-up flags
    @(posedge clock);
    enable <= 1'b1;
    resetn <= 1'b0;
    @(posedge clock);
    #1;
    `chk(core_status_ff, 8'h18)
    `chk(result_ff, 8'h00)
    // the first instruction after release must be taken normally
    @(posedge clock);
    resetn <= 1'b1;
    u_core_status_exec_model.issue(4'(core_status_pkg::op_add), 8'h01, 8'h01, 1'b0, 1'b0);
    #1;
    `chk(core_status_ff, 8'h18)
    `chk(result_ff, 8'h02)
    results();
  end
endmodule : core_status_flags_and_bank_layout_tb_top
`default_nettype wire
